// ### src/debug_cause_latch.sv
`timescale 1ns/1ps
`default_nettype none
module debug_cause_latch (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Capture
  input wire logic load,
  input wire logic [5:0] cause_in,
  // Held cause
  output logic [5:0] cause_q
);

  debug_status_pkg::cause_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    // Whole vector replaced so stale causes from an earlier entry vanish
    if (load) begin
      s_d.cause = cause_in;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q.cause <= debug_status_pkg::CAUSE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign cause_q = s_q.cause;

endmodule // debug_cause_latch
`default_nettype wire

// ### src/debug_status_control.sv
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module debug_status_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Debug entry and return
  input wire logic debug_entry_req,
  input wire logic debug_return_instruction,
  // Cause of the entering debug exception
  input wire logic cause_step,
  input wire logic cause_software_break,
  input wire logic cause_load_break,
  input wire logic cause_store_break,
  input wire logic cause_fetch_break,
  input wire logic cause_halt_interrupt,
  // Exception raised in the same cycle as the debug exception
  input wire logic other_exc_pending,
  input wire logic other_exc_is_reset,
  input wire logic other_exc_is_nmi,
  input wire logic other_exc_is_refill,
  // Load/store faults
  input wire logic ls_translation_fault,
  input wire logic ls_bus_fault,
  // Control outputs
  output logic handler_active_flag,
  output logic exception_mask,
  output logic step_active,
  output logic test_port_reset,
  output logic exc_regs_update,
  output logic resume_address_load,
  output logic [5:0] cause_status
);

  debug_status_pkg::status_state_type s_q, s_d;

  logic reg_hit;
  logic wr_hit;
  logic rd_hit;
  logic entry_take;
  logic return_take;
  logic other_coincident;
  logic tlb_set;
  logic bus_set;
  logic [5:0] cause_vec;
  logic [5:0] cause_q;
  logic [31:0] read_word;

  assign reg_hit = (reg_addr == debug_status_pkg::DEBUG_REG_NUM);
  assign wr_hit = reg_wr && reg_hit;
  assign rd_hit = reg_rd && reg_hit;

  // Nested debug exceptions are masked while the handler runs
  assign entry_take = debug_entry_req && !s_q.handler_active;
  assign return_take = debug_return_instruction && s_q.handler_active;

  // Reset, NMI and refill have their own status bits outside this half
  assign other_coincident = other_exc_pending && !other_exc_is_reset
    && !other_exc_is_nmi && !other_exc_is_refill;

  assign tlb_set = ls_translation_fault && s_q.handler_active;
  assign bus_set = ls_bus_fault && s_q.handler_active;

  always_comb begin
    cause_vec = 6'h00;
    cause_vec[debug_status_pkg::CAUSE_STEP] = cause_step;
    cause_vec[debug_status_pkg::CAUSE_SWBRK] = cause_software_break;
    cause_vec[debug_status_pkg::CAUSE_LOAD] = cause_load_break;
    cause_vec[debug_status_pkg::CAUSE_STORE] = cause_store_break;
    cause_vec[debug_status_pkg::CAUSE_FETCH] = cause_fetch_break;
    cause_vec[debug_status_pkg::CAUSE_HALT] = cause_halt_interrupt;
  end

  debug_cause_latch u_cause (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .load(entry_take),
    .cause_in(cause_vec),
    .cause_q(cause_q)
  );

  // Read image; bits 9 and 6 and everything unnamed stay zero
  always_comb begin
    read_word = debug_status_pkg::READ_RESET;
    read_word[debug_status_pkg::HANDLER_ACTIVE_BIT] = s_q.handler_active;
    read_word[debug_status_pkg::OTHER_EXC_BIT] = s_q.other_exc;
    read_word[debug_status_pkg::TLB_FLAG_BIT] = s_q.tlb_flag;
    read_word[debug_status_pkg::BUS_FLAG_BIT] = s_q.bus_flag;
    read_word[debug_status_pkg::STEP_EN_BIT] = s_q.step_en;
    read_word[debug_status_pkg::TEST_RST_BIT] = s_q.test_rst;
    read_word[debug_status_pkg::CAUSE_LSB +: debug_status_pkg::CAUSE_W] = cause_q;
  end

  always_comb begin
    s_d = s_q;
    s_d.test_rst_pulse = 1'b0;
    s_d.regs_update = 1'b0;
    s_d.resume_load = 1'b0;

    if (entry_take) begin
      s_d.handler_active = 1'b1;
      s_d.other_exc = other_coincident;
      // Usual registers updated for a coincident exception only; resume address takes the faulting PC
      s_d.regs_update = other_coincident;
      s_d.resume_load = 1'b1;
    end else if (return_take) begin
      s_d.handler_active = 1'b0;
    end

    // Only four fields take writes; the rest are read-only
    if (wr_hit) begin
      s_d.tlb_flag = s_q.tlb_flag && reg_wdata[debug_status_pkg::TLB_FLAG_BIT];
      s_d.bus_flag = s_q.bus_flag && reg_wdata[debug_status_pkg::BUS_FLAG_BIT];
      s_d.step_en = reg_wdata[debug_status_pkg::STEP_EN_BIT];
      s_d.test_rst = reg_wdata[debug_status_pkg::TEST_RST_BIT];
      s_d.test_rst_pulse = reg_wdata[debug_status_pkg::TEST_RST_BIT];
    end

    // Hardware set after the write so a fault in the clearing cycle is kept
    if (tlb_set) begin
      s_d.tlb_flag = 1'b1;
    end
    if (bus_set) begin
      s_d.bus_flag = 1'b1;
    end

    // Derived from next state so the output never lags the flag
    s_d.step_active = s_d.step_en && !s_d.handler_active;

    s_d.rdata = rd_hit ? read_word : debug_status_pkg::READ_RESET;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign handler_active_flag = s_q.handler_active;
  // Interrupts, NMI, TLB and bus faults are held off by the core while set
  assign exception_mask = s_q.handler_active;
  assign step_active = s_q.step_active;
  assign test_port_reset = s_q.test_rst_pulse;
  assign exc_regs_update = s_q.regs_update;
  assign resume_address_load = s_q.resume_load;
  assign cause_status = cause_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_entry_with_other;
    entry_take && other_coincident;
  endsequence

  sequence s_marked_and_updated;
    s_q.other_exc && exc_regs_update && resume_address_load;
  endsequence

  sequence s_resume_pulse;
    resume_address_load ##1 !resume_address_load;
  endsequence

  sequence s_reset_pulse;
    test_port_reset ##1 !test_port_reset;
  endsequence

  property p_other_exc_set;
    s_entry_with_other |=> s_q.other_exc;
  endproperty
  a_other_exc_set: assert property (p_other_exc_set)
    else $error("other exception status not set on coincident entry");

  property p_regs_update;
    s_entry_with_other |=> s_marked_and_updated ##1 !exc_regs_update;
  endproperty
  a_regs_update: assert property (p_regs_update)
    else $error("coincident exception update pulse wrong");

  property p_tlb_set_wins;
    (ls_translation_fault && handler_active_flag) |=> s_q.tlb_flag;
  endproperty
  a_tlb_set_wins: assert property (p_tlb_set_wins)
    else $error("translation fault flag lost");

  property p_tlb_clear;
    (wr_hit && !reg_wdata[11] && !tlb_set) |=> !s_q.tlb_flag;
  endproperty
  a_tlb_clear: assert property (p_tlb_clear)
    else $error("translation fault flag not cleared by zero write");

  property p_bus_flag;
    ((ls_bus_fault && handler_active_flag) |=> s_q.bus_flag)
      and ((wr_hit && reg_wdata[10] && !bus_set) |=> $stable(s_q.bus_flag));
  endproperty
  a_bus_flag: assert property (p_bus_flag)
    else $error("bus fault flag wrong");

  property p_step_enable;
    wr_hit |=> s_q.step_en == $past(reg_wdata[8]);
  endproperty
  a_step_enable: assert property (p_step_enable)
    else $error("step enable did not take written value");

  property p_step_inactive;
    handler_active_flag |-> !step_active;
  endproperty
  a_step_inactive: assert property (p_step_inactive)
    else $error("stepping active in handler");

  property p_test_reset;
    (wr_hit && reg_wdata[7]) ##1 !(wr_hit && reg_wdata[7]) |-> s_reset_pulse;
  endproperty
  a_test_reset: assert property (p_test_reset)
    else $error("test port reset pulse wrong");

  property p_cause_capture;
    entry_take |=> cause_status == $past(cause_vec);
  endproperty
  a_cause_capture: assert property (p_cause_capture)
    else $error("cause bits not captured at entry");

  property p_halt_cause;
    (entry_take && cause_halt_interrupt) |=> cause_status[5];
  endproperty
  a_halt_cause: assert property (p_halt_cause)
    else $error("debug interrupt cause not recorded");

  property p_enter_return;
    (entry_take |=> handler_active_flag && exception_mask)
      and (return_take |=> !handler_active_flag);
  endproperty
  a_enter_return: assert property (p_enter_return)
    else $error("handler flag sequencing wrong");

  property p_causes_readonly;
    (wr_hit && !entry_take) |=> $stable(cause_status) && $stable(s_q.other_exc);
  endproperty
  a_causes_readonly: assert property (p_causes_readonly)
    else $error("read-only field changed by write");

  property p_reserved_zero;
    reg_rd |=> reg_rdata[9] == 1'b0 && reg_rdata[6] == 1'b0 && reg_rdata[29:13] == 17'h00000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read non-zero");

  property p_fetch_cause;
    (entry_take && cause_fetch_break) |=> cause_status[debug_status_pkg::CAUSE_FETCH];
  endproperty
  a_fetch_cause: assert property (p_fetch_cause)
    else $error("instruction break cause not recorded");

  property p_store_cause;
    (entry_take && cause_store_break) |=> cause_status[debug_status_pkg::CAUSE_STORE];
  endproperty
  a_store_cause: assert property (p_store_cause)
    else $error("store break cause not recorded");

  property p_load_cause;
    (entry_take && cause_load_break) |=> cause_status[debug_status_pkg::CAUSE_LOAD];
  endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("load break cause not recorded");

  property p_swbrk_cause;
    (entry_take && cause_software_break) |=> cause_status[debug_status_pkg::CAUSE_SWBRK];
  endproperty
  a_swbrk_cause: assert property (p_swbrk_cause)
    else $error("software breakpoint cause not recorded");

  property p_step_cause;
    (entry_take && cause_step) |=> cause_status[debug_status_pkg::CAUSE_STEP];
  endproperty
  a_step_cause: assert property (p_step_cause)
    else $error("single step cause not recorded");

  property p_other_excluded;
    (entry_take && (other_exc_is_reset || other_exc_is_nmi || other_exc_is_refill))
      |=> !s_q.other_exc && !exc_regs_update;
  endproperty
  a_other_excluded: assert property (p_other_excluded)
    else $error("excluded exception class marked as coincident");

  property p_plain_entry;
    (entry_take && !other_exc_pending) |=> resume_address_load && !exc_regs_update;
  endproperty
  a_plain_entry: assert property (p_plain_entry)
    else $error("plain entry update pulses wrong");

  property p_resume_pulse;
    entry_take |=> s_resume_pulse;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse)
    else $error("resume address load pulse wrong");

  property p_tlb_one_ignored;
    (wr_hit && reg_wdata[debug_status_pkg::TLB_FLAG_BIT] && !tlb_set)
      |=> $stable(s_q.tlb_flag);
  endproperty
  a_tlb_one_ignored: assert property (p_tlb_one_ignored)
    else $error("translation fault flag changed by one write");

  property p_bus_clear;
    (wr_hit && !reg_wdata[debug_status_pkg::BUS_FLAG_BIT] && !bus_set) |=> !s_q.bus_flag;
  endproperty
  a_bus_clear: assert property (p_bus_clear)
    else $error("bus fault flag not cleared by zero write");

  property p_faults_outside;
    (!handler_active_flag && !wr_hit) |=> $stable(s_q.tlb_flag) && $stable(s_q.bus_flag);
  endproperty
  a_faults_outside: assert property (p_faults_outside)
    else $error("fault flag changed outside the handler");

  property p_step_on;
    (s_q.step_en && !handler_active_flag) |-> step_active;
  endproperty
  a_step_on: assert property (p_step_on)
    else $error("stepping off although enabled outside handler");

  property p_entry_masked;
    (debug_entry_req && handler_active_flag) |=> !resume_address_load && $stable(cause_status);
  endproperty
  a_entry_masked: assert property (p_entry_masked)
    else $error("nested debug entry not masked");

  property p_return_refused;
    (debug_return_instruction && !handler_active_flag && !debug_entry_req)
      |=> !handler_active_flag;
  endproperty
  a_return_refused: assert property (p_return_refused)
    else $error("return outside handler had an effect");

  property p_test_bit_kept;
    wr_hit |=> s_q.test_rst == $past(reg_wdata[debug_status_pkg::TEST_RST_BIT]);
  endproperty
  a_test_bit_kept: assert property (p_test_bit_kept)
    else $error("test reset bit did not take written value");

endmodule // debug_status_control
`default_nettype wire

// ### src/debug_status_pkg.sv
// Functional notes
// - Coincident other exception (not reset, NMI, refill) at debug entry sets bit 12.
// - Coincident exception updates usual exception registers, resume address gets no vector.
// - Bit 11 sets on load/store TLB fault in handler; write 0 clears, set wins.
// - Bit 10 sets on load/store bus fault in handler; write 0 clears, set wins.
// - Bit 8 is read/write step enable.
// - Stepping stays off while the handler runs.
// - Writing 1 to bit 7 resets the test port unit; bit resets to 0.
// - Bit 5 marks a debug interrupt cause.
// - Bit 4 marks an instruction address break cause.
// - Bit 3 marks a store data break cause.
// - Bit 2 marks a load data break cause.
// - Bit 1 marks a software breakpoint instruction cause.
// - Bit 0 marks a single-step exception cause.
// - Handler flag sets on debug entry, clears on debug return, masks other exceptions.
// - Only bits 11, 10, 8 and 7 take software writes.
package debug_status_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CAUSE_W = 6;

  // Coprocessor register number of the debug status word
  localparam logic [4:0] DEBUG_REG_NUM = 5'h17;

  // Field positions
  localparam int unsigned HANDLER_ACTIVE_BIT = 30;
  localparam int unsigned OTHER_EXC_BIT = 12;
  localparam int unsigned TLB_FLAG_BIT = 11;
  localparam int unsigned BUS_FLAG_BIT = 10;
  localparam int unsigned STEP_EN_BIT = 8;
  localparam int unsigned TEST_RST_BIT = 7;
  localparam int unsigned CAUSE_LSB = 0;

  // Cause vector order, bit 0 upward
  localparam int unsigned CAUSE_STEP = 0;
  localparam int unsigned CAUSE_SWBRK = 1;
  localparam int unsigned CAUSE_LOAD = 2;
  localparam int unsigned CAUSE_STORE = 3;
  localparam int unsigned CAUSE_FETCH = 4;
  localparam int unsigned CAUSE_HALT = 5;

  localparam logic [5:0] CAUSE_RESET = 6'h00;
  localparam logic [31:0] READ_RESET = 32'h0000_0000;

  // Chain targets for a coincident general exception, used by handler software
  localparam logic [31:0] CHAIN_VEC_BOOT = 32'hBFC0_0380;
  localparam logic [31:0] CHAIN_VEC_NORMAL = 32'h8000_0180;

  typedef struct packed {
    logic [5:0] cause;
  } cause_state_type;

  typedef struct packed {
    logic handler_active;
    logic other_exc;
    logic tlb_flag;
    logic bus_flag;
    logic step_en;
    logic test_rst;
    logic test_rst_pulse;
    logic step_active;
    logic regs_update;
    logic resume_load;
    logic [31:0] rdata;
  } status_state_type;

endpackage

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [5:0] cause;
    logic [3:0] oth;
    logic coincident_other_exception_status;
  } row_type;
  localparam logic [4:0] REG = debug_status_pkg::DEBUG_REG_NUM;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic entry = 1'b0;
  logic ret_i = 1'b0;
  logic tlb_f = 1'b0;
  logic bus_f = 1'b0;
  logic [5:0] cause_v = 6'h00;
  // Pending, reset, nmi, refill
  logic [3:0] oth = 4'h0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_v;
  logic hflag, emask, step_act, tpr, upd, rload;
  logic [5:0] cause_st;
  int mismatches = 0;
  int check_count = 0;
  row_type rows [10] = '{'{6'h01, 4'h0, 1'b0}, '{6'h02, 4'h0, 1'b0}, '{6'h04, 4'h0, 1'b0},
    '{6'h08, 4'h0, 1'b0}, '{6'h10, 4'h0, 1'b0}, '{6'h20, 4'h0, 1'b0}, '{6'h10, 4'h8, 1'b1},
    '{6'h10, 4'hC, 1'b0}, '{6'h01, 4'hA, 1'b0}, '{6'h02, 4'h9, 1'b0}};

  debug_status_control i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_entry_req(entry),
    .debug_return_instruction(ret_i), .cause_step(cause_v[0]),
    .cause_software_break(cause_v[1]), .cause_load_break(cause_v[2]),
    .cause_store_break(cause_v[3]), .cause_fetch_break(cause_v[4]),
    .cause_halt_interrupt(cause_v[5]), .other_exc_pending(oth[3]),
    .other_exc_is_reset(oth[2]), .other_exc_is_nmi(oth[1]), .other_exc_is_refill(oth[0]),
    .ls_translation_fault(tlb_f), .ls_bus_fault(bus_f), .handler_active_flag(hflag),
    .exception_mask(emask), .step_active(step_act), .test_port_reset(tpr),
    .exc_regs_update(upd), .resume_address_load(rload), .cause_status(cause_st)
  );

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One request cycle; outputs are sampled just after the edge that takes it
  task automatic cyc(input logic [4:0] a, input logic [31:0] d, input logic w, input logic r,
      input logic e, input logic rt, input logic [5:0] c, input logic [3:0] o,
      input logic t, input logic b);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= r;
    entry <= e;
    ret_i <= rt;
    cause_v <= c;
    oth <= o;
    tlb_f <= t;
    bus_f <= b;
    @(posedge clk_sys);
    {reg_wr, reg_rd, entry, ret_i, tlb_f, bus_f} <= 6'h00;
    cause_v <= 6'h00;
    oth <= 4'h0;
    #1;
    rd_v = reg_rdata;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    cyc(a, d, 1'b1, 1'b0, 1'b0, 1'b0, 6'h00, 4'h0, 1'b0, 1'b0);
  endtask

  task automatic rd(input logic [4:0] a);
    cyc(a, 32'h0000_0000, 1'b0, 1'b1, 1'b0, 1'b0, 6'h00, 4'h0, 1'b0, 1'b0);
  endtask

  task automatic enter(input logic [5:0] c, input logic [3:0] o);
    cyc(REG, 32'h0000_0000, 1'b0, 1'b0, 1'b1, 1'b0, c, o, 1'b0, 1'b0);
  endtask

  task automatic leave;
    cyc(REG, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b1, 6'h00, 4'h0, 1'b0, 1'b0);
  endtask

  task automatic fault(input logic t, input logic b, input logic w, input logic [31:0] d);
    cyc(REG, d, w, 1'b0, 1'b0, 1'b0, 6'h00, 4'h0, t, b);
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask

  // Hang guard
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      enter(rows[i].cause, rows[i].oth);
      chk(hflag, 1'b1);
      chk(emask, 1'b1);
      chk(rload, 1'b1);
      chk(upd, rows[i].coincident_other_exception_status);
      chk(cause_st, rows[i].cause);
      rd(REG);
      chk(rd_v, {2'b01, 17'h00000, rows[i].coincident_other_exception_status, 6'h00, rows[i].cause});
      chk(rload, 1'b0);
      leave();
      chk(hflag, 1'b0);
      chk(cause_st, rows[i].cause);
    end
    wr(REG, 32'hFFFF_FFFF);
    chk(tpr, 1'b1);
    rd(REG);
    chk(rd_v, 32'h0000_0182);
    chk(tpr, 1'b0);
    chk(step_act, 1'b1);
    do_reset();
    rd(REG);
    chk(rd_v, 32'h0000_0000);
    chk(cause_st, 6'h00);
    chk(step_act, 1'b0);
    wr(5'h05, 32'h0000_0180);
    rd(REG);
    chk(rd_v, 32'h0000_0000);
    fault(1'b1, 1'b1, 1'b0, 32'h0000_0000);
    rd(REG);
    chk(rd_v, 32'h0000_0000);
    wr(REG, 32'h0000_0100);
    chk(step_act, 1'b1);
    enter(6'h01, 4'h0);
    chk(step_act, 1'b0);
    enter(6'h20, 4'h8);
    chk(rload, 1'b0);
    chk(cause_st, 6'h01);
    fault(1'b1, 1'b0, 1'b0, 32'h0000_0000);
    rd(REG);
    chk(rd_v, 32'h4000_0901);
    fault(1'b0, 1'b1, 1'b0, 32'h0000_0000);
    rd(REG);
    chk(rd_v, 32'h4000_0D01);
    wr(REG, 32'h0000_0100);
    rd(REG);
    chk(rd_v, 32'h4000_0101);
    // Set and zero write in the same cycle: the set must win
    fault(1'b1, 1'b1, 1'b1, 32'h0000_0100);
    rd(REG);
    chk(rd_v, 32'h4000_0D01);
    leave();
    @(posedge clk_sys);
    #1;
    chk(step_act, 1'b1);
    wr(REG, 32'h0000_0080);
    chk(tpr, 1'b1);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
